// ### src/ccdc_regs.svh
// Purpose: Register offsets, field positions and reset values of the channel trim block
// Assumes: Byte-wide registers on the device's own control port
// Notes:   Definitions only
`ifndef CCDC_REGS_SVH
`define CCDC_REGS_SVH
`define CCDC_OFS_GAIN_TRIM   8'h44
`define CCDC_OFS_PHASE_TRIM  8'h45
`define CCDC_OFS_SCAN_SEL    8'h64
`define CCDC_OFS_THRESH_ONE  8'h65
`define CCDC_RST_GAIN_TRIM   8'h80
`define CCDC_RST_PHASE_TRIM  8'h00
`define CCDC_RST_SCAN_SEL    8'h00
`define CCDC_RST_THRESH_ONE  8'h37
`define CCDC_GAIN_MSB        7
`define CCDC_GAIN_LSB        4
`define CCDC_GAIN_UNITY      4'h8
`define CCDC_BIT_CH1_SCAN    7
`define CCDC_BIT_CH2_SCAN    6
`define CCDC_BIT_SE_NEG      1
`define CCDC_BIT_AC_PINS     0
`define CCDC_INCFG_SE        2'h1
`define CCDC_INCFG_DIFF      2'h0
`define CCDC_SCAN_STEPS      3'h4
`endif

// ### src/ccdc_pkg.sv
// Purpose: Types of the channel trim and diagnostic scan block
// Assumes: No register header included; widths and state codes written directly
// Notes:   Types only
package ccdc_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccdc_bus_type;

   typedef struct packed {
      logic       coupling_dc;
      logic [1:0] input_config;
   } ccdc_chcfg_type;

   typedef enum logic [3:0] {
      SC_IDLE = 4'b0001,
      SC_PIN  = 4'b0010,
      SC_NEXT = 4'b0100,
      SC_WRAP = 4'b1000
   } ccdc_scan_type;

   typedef struct packed {
      logic [7:0]    gain_trim;
      logic [7:0]    phase_trim;
      logic [7:0]    scan_sel;
      logic [7:0]    thresh_one;
      logic [7:0]    rdata;
      logic          rvalid;
      logic [3:0]    gain_code;
      logic [7:0]    delay_cycles;
      logic [3:0]    pin_mask;
      ccdc_scan_type scan_st;
      logic [2:0]    pin_idx;
      logic [3:0]    active_mask;
      logic [3:0]    pin_sel;
      logic          pin_valid;
      logic [7:0]    dly_cnt;
      logic          sample_out;
   } ccdc_state_type;
endpackage : ccdc_pkg

// ### src/ccdc_top.sv
// Purpose: Channel-2 gain/phase trims and diagnostic pin-scan selection registers
// Assumes: Control port and modulator strobe synchronous to ref_clk_i
// Notes:   Pin order first_pos, first_neg, second_pos, second_neg
`timescale 1ns/1ps
`include "ccdc_regs.svh"
module ccdc_top (
   input  wire logic                    ref_clk_i,
   input  wire logic                    resetn_i,
   input  wire ccdc_pkg::ccdc_bus_type  bus_i,
   input  wire ccdc_pkg::ccdc_chcfg_type first_cfg_i,
   input  wire ccdc_pkg::ccdc_chcfg_type second_cfg_i,
   input  wire logic                    mod_clk_en_i,
   input  wire logic                    sample_in_i,
   input  wire logic                    scan_step_i,
   output logic [7:0]                   rdata_o,
   output logic                         rvalid_o,
   output logic [3:0]                   gain_code_o,
   output logic [7:0]                   delay_cycles_o,
   output logic [3:0]                   pin_mask_o,
   output logic [3:0]                   pin_sel_o,
   output logic                         pin_valid_o,
   output logic                         sample_o
);
   import ccdc_pkg::*;

   ccdc_state_type s_r;
   ccdc_state_type s_nxt;
   logic [255:0]   dline_r;
   logic           ch1_se;
   logic           ch2_se;
   logic [3:0]     mask;

   // Single-ended classification of each channel
   assign ch1_se = (first_cfg_i.input_config == `CCDC_INCFG_SE);
   assign ch2_se = (second_cfg_i.input_config == `CCDC_INCFG_SE);

   // Pin mask: enable and single-ended negative exclusion, then AC exclusion
   always_comb begin
      mask[0] = s_r.scan_sel[`CCDC_BIT_CH1_SCAN];
      mask[1] = s_r.scan_sel[`CCDC_BIT_CH1_SCAN] & (~ch1_se | s_r.scan_sel[`CCDC_BIT_SE_NEG]);
      mask[2] = s_r.scan_sel[`CCDC_BIT_CH2_SCAN];
      mask[3] = s_r.scan_sel[`CCDC_BIT_CH2_SCAN] & (~ch2_se | s_r.scan_sel[`CCDC_BIT_SE_NEG]);
      if (!first_cfg_i.coupling_dc && !s_r.scan_sel[`CCDC_BIT_AC_PINS]) begin
         mask[1:0] = 2'h0;
      end
      if (!second_cfg_i.coupling_dc && !s_r.scan_sel[`CCDC_BIT_AC_PINS]) begin
         mask[3:2] = 2'h0;
      end
   end

   always_comb begin
      s_nxt        = s_r;
      s_nxt.rvalid = 1'b0;
      s_nxt.pin_valid = 1'b0;
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            // Low nibble forced to zero so it reads back as zero
            `CCDC_OFS_GAIN_TRIM:  s_nxt.gain_trim = {bus_i.wdata[`CCDC_GAIN_MSB:`CCDC_GAIN_LSB], 4'h0};
            `CCDC_OFS_PHASE_TRIM: s_nxt.phase_trim = bus_i.wdata;
            `CCDC_OFS_SCAN_SEL:   s_nxt.scan_sel = bus_i.wdata;
            `CCDC_OFS_THRESH_ONE: s_nxt.thresh_one = bus_i.wdata;
            default: ;
         endcase
      end
      if (bus_i.rd) begin
         s_nxt.rvalid = 1'b1;
         unique case (bus_i.addr)
            `CCDC_OFS_GAIN_TRIM:  s_nxt.rdata = s_r.gain_trim;
            `CCDC_OFS_PHASE_TRIM: s_nxt.rdata = s_r.phase_trim;
            `CCDC_OFS_SCAN_SEL:   s_nxt.rdata = s_r.scan_sel;
            `CCDC_OFS_THRESH_ONE: s_nxt.rdata = s_r.thresh_one;
            default:              s_nxt.rdata = 8'h00;
         endcase
      end
      s_nxt.gain_code    = s_r.gain_trim[`CCDC_GAIN_MSB:`CCDC_GAIN_LSB];
      s_nxt.delay_cycles = s_r.phase_trim;
      s_nxt.pin_mask     = mask;
      // Delay tap sampled on modulator strobes only
      if (mod_clk_en_i) begin
         s_nxt.sample_out = (s_r.phase_trim == 8'h00) ? sample_in_i
                                                       : dline_r[s_r.phase_trim - 8'h01];
      end
      // Scan sequencer: mask latched per pass so mid-pass writes apply next pass
      unique case (s_r.scan_st)
         SC_IDLE: begin
            if (scan_step_i && (mask != 4'h0)) begin
               s_nxt.active_mask = mask;
               s_nxt.pin_idx     = 3'h0;
               s_nxt.scan_st     = SC_PIN;
            end
         end
         SC_PIN: begin
            if (s_r.active_mask[s_r.pin_idx[1:0]]) begin
               s_nxt.pin_sel   = 4'h1 << s_r.pin_idx[1:0];
               s_nxt.pin_valid = 1'b1;
            end
            s_nxt.scan_st = SC_NEXT;
         end
         SC_NEXT: begin
            s_nxt.pin_idx = s_r.pin_idx + 3'h1;
            s_nxt.scan_st = (s_r.pin_idx + 3'h1 == `CCDC_SCAN_STEPS) ? SC_WRAP : SC_PIN;
         end
         SC_WRAP: begin
            s_nxt.pin_sel = 4'h0;
            s_nxt.scan_st = SC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_r            <= '0;
         s_r.gain_trim  <= `CCDC_RST_GAIN_TRIM;
         s_r.phase_trim <= `CCDC_RST_PHASE_TRIM;
         s_r.scan_sel   <= `CCDC_RST_SCAN_SEL;
         s_r.thresh_one <= `CCDC_RST_THRESH_ONE;
         s_r.gain_code  <= `CCDC_GAIN_UNITY;
         s_r.scan_st    <= SC_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Shift register holds 256 modulator samples; flops traded for exact delay
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         dline_r <= '0;
      end else if (mod_clk_en_i) begin
         dline_r <= {dline_r[254:0], sample_in_i};
      end
   end

   assign rdata_o        = s_r.rdata;
   assign rvalid_o       = s_r.rvalid;
   assign gain_code_o    = s_r.gain_code;
   assign delay_cycles_o = s_r.delay_cycles;
   assign pin_mask_o     = s_r.pin_mask;
   assign pin_sel_o      = s_r.pin_sel;
   assign pin_valid_o    = s_r.pin_valid;
   assign sample_o       = s_r.sample_out;

   // Register bank checks
   gain_low_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_r.gain_trim[3:0] == 4'h0) else $error("gain trim low bits not zero");
   gain_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      bus_i.wr && bus_i.addr == `CCDC_OFS_GAIN_TRIM |-> ##2
      gain_code_o == $past(bus_i.wdata[`CCDC_GAIN_MSB:`CCDC_GAIN_LSB], 2))
      else $error("gain code did not follow write");
   gain_reset_a: assert property (@(posedge ref_clk_i)
      !resetn_i |=> gain_code_o == `CCDC_GAIN_UNITY && s_r.gain_trim == `CCDC_RST_GAIN_TRIM)
      else $error("gain trim reset value wrong");
   scan_store_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      bus_i.wr && bus_i.addr == `CCDC_OFS_SCAN_SEL |=> s_r.scan_sel == $past(bus_i.wdata))
      else $error("scan select not stored in full");
   read_answer_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      bus_i.rd |=> rvalid_o)
      else $error("read not answered in one cycle");
   phase_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      bus_i.wr && bus_i.addr == `CCDC_OFS_PHASE_TRIM |-> ##2 delay_cycles_o == $past(bus_i.wdata, 2))
      else $error("delay did not follow write");
   reset_zero_a: assert property (@(posedge ref_clk_i)
      !resetn_i |=> s_r.phase_trim == 8'h00 && s_r.scan_sel == 8'h00)
      else $error("reset values wrong");
   // Scan selection checks; mask follows the select one cycle later
   ch1_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !s_r.scan_sel[`CCDC_BIT_CH1_SCAN] |=> pin_mask_o[1:0] == 2'h0)
      else $error("first channel scanned");
   ch2_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !s_r.scan_sel[`CCDC_BIT_CH2_SCAN] |=> pin_mask_o[3:2] == 2'h0)
      else $error("second channel scanned");
   ch1_on_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_r.scan_sel[`CCDC_BIT_CH1_SCAN] && first_cfg_i.coupling_dc |=> pin_mask_o[0])
      else $error("first channel positive pin not scanned");
   ch2_on_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_r.scan_sel[`CCDC_BIT_CH2_SCAN]
      && (second_cfg_i.coupling_dc || s_r.scan_sel[`CCDC_BIT_AC_PINS]) |=> pin_mask_o[2])
      else $error("second channel positive pin not scanned");
   se_neg_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      ch2_se && !s_r.scan_sel[`CCDC_BIT_SE_NEG] |=> !pin_mask_o[3])
      else $error("single-ended negative scanned");
   se_neg_one_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      ch1_se && !s_r.scan_sel[`CCDC_BIT_SE_NEG] |=> !pin_mask_o[1])
      else $error("first single-ended negative scanned");
   ac_excl_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !first_cfg_i.coupling_dc && !s_r.scan_sel[`CCDC_BIT_AC_PINS] |=> pin_mask_o[1:0] == 2'h0)
      else $error("AC-coupled pins scanned");
   ac_excl_two_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !second_cfg_i.coupling_dc && !s_r.scan_sel[`CCDC_BIT_AC_PINS] |=> pin_mask_o[3:2] == 2'h0)
      else $error("second AC-coupled pins scanned");
   // Pass mask is latched, so a strobed pin must belong to it
   pin_pick_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      pin_valid_o |-> $onehot(pin_sel_o) && (pin_sel_o & s_r.active_mask) != 4'h0)
      else $error("scanned pin outside latched mask");
   // Zero phase trim is a one-register pass-through of the strobed sample
   pass_thru_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      mod_clk_en_i && s_r.phase_trim == `CCDC_RST_PHASE_TRIM |=> sample_o == $past(sample_in_i))
      else $error("zero delay not pass-through");
   readback_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      bus_i.wr && bus_i.addr == `CCDC_OFS_SCAN_SEL ##1 bus_i.rd && !bus_i.wr
      && bus_i.addr == `CCDC_OFS_SCAN_SEL |=> rdata_o == $past(bus_i.wdata, 2))
      else $error("readback mismatch");
   scan_cov_c: cover property (@(posedge ref_clk_i) pin_valid_o && pin_sel_o == 4'h8);
   delay_cov_c: cover property (@(posedge ref_clk_i) mod_clk_en_i && s_r.phase_trim == 8'hff);
   ac_cov_c: cover property (@(posedge ref_clk_i) !second_cfg_i.coupling_dc && pin_mask_o[2]);
   rd_cov_c: cover property (@(posedge ref_clk_i) rvalid_o && rdata_o != 8'h00);
   se_cov_c: cover property (@(posedge ref_clk_i)
      ch1_se && s_r.scan_sel[`CCDC_BIT_SE_NEG] && pin_mask_o[1]);
endmodule : ccdc_top

// ### tb/ccdc_top_test.sv
// Purpose: Self-checking bench for the channel trim and scan select registers
// Assumes: Reads answered one cycle after the strobe, trims and mask settle two cycles
// Notes:   Read data is checked from a queue of expected values by a separate monitor
`timescale 1ns/1ps
`include "ccdc_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module ccdc_top_test;
   import ccdc_pkg::*;
   logic           ref_clk_i = 0;
   logic           resetn_i = 0;
   logic           mod_clk_en_i = 0;
   logic           sample_in_i = 0;
   logic           scan_step_i = 0;
   ccdc_bus_type   bus_i = '0;
   ccdc_chcfg_type first_cfg_i = '0;
   ccdc_chcfg_type second_cfg_i = '0;
   logic [7:0]     rdata_o, delay_cycles_o, e, g, p, s;
   logic [3:0]     gain_code_o, pin_mask_o, pin_sel_o, m;
   logic           rvalid_o, pin_valid_o, sample_o;
   int             num_errors = 0;
   int             checks = 0;
   int             n;
   logic [7:0]     exp_q[$];
   logic [255:0]   hist = '0;
   logic           smp_exp = 0;
   logic           smp_pend = 0;
   logic           smp_on = 0;

   ccdc_top i_ccdc_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
      .first_cfg_i(first_cfg_i), .second_cfg_i(second_cfg_i), .mod_clk_en_i(mod_clk_en_i),
      .sample_in_i(sample_in_i), .scan_step_i(scan_step_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .gain_code_o(gain_code_o), .delay_cycles_o(delay_cycles_o),
      .pin_mask_o(pin_mask_o), .pin_sel_o(pin_sel_o), .pin_valid_o(pin_valid_o),
      .sample_o(sample_o));

   initial forever #5 ref_clk_i = ~ref_clk_i;

   // Keeps the delay line busy so its logic is exercised throughout
   always @(posedge ref_clk_i) begin
      #1 mod_clk_en_i = $urandom;
      sample_in_i = $urandom;
   end

   always @(posedge ref_clk_i) begin
      if (rvalid_o === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         `CHK("rdata_o", e, rdata_o)
      end
   end

   // Expected delayed sample from a history of strobed inputs and the programmed trim
   always @(posedge ref_clk_i) begin
      if (smp_pend) `CHK("sample_o", smp_exp, sample_o)
      smp_pend = mod_clk_en_i && smp_on && resetn_i;
      if (mod_clk_en_i && resetn_i) begin
         smp_exp = (p == 8'h00) ? sample_in_i : hist[p - 8'h01];
         hist = {hist[254:0], sample_in_i};
      end
   end

   // One whole-bus assignment per step so back-to-back strobes never glitch
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk_i);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      bus_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_i);
      #1;
   endtask : rd

   task automatic settle();
      bus_i = '0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask : settle

   // AC channels drop out unless included; single-ended negative pin needs its own bit
   function automatic logic [1:0] pins(input logic en, input ccdc_chcfg_type c,
                                       input logic [7:0] sel);
      logic on;
      on = en & (c.coupling_dc | sel[`CCDC_BIT_AC_PINS]);
      return {on & (c.input_config != `CCDC_INCFG_SE | sel[`CCDC_BIT_SE_NEG]), on};
   endfunction : pins

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   initial begin
      #100000;
      num_errors++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      void'($urandom(11));
      repeat (8) @(posedge ref_clk_i);
      #1 resetn_i = 1'b1;
      rd(`CCDC_OFS_GAIN_TRIM, `CCDC_RST_GAIN_TRIM);
      rd(`CCDC_OFS_PHASE_TRIM, 8'h00);
      rd(`CCDC_OFS_SCAN_SEL, 8'h00);
      rd(`CCDC_OFS_THRESH_ONE, `CCDC_RST_THRESH_ONE);
      rd(8'h50, 8'h00);
      settle();
      `CHK("gain_code_o", `CCDC_GAIN_UNITY, gain_code_o)
      `CHK("delay_cycles_o", 8'h00, delay_cycles_o)
      `CHK("pin_mask_o", 4'h0, pin_mask_o)
      $display("test reset_values done");
      for (int i = 0; i < 16; i++) begin
         g = {i[3:0], 4'($urandom)};
         p = (i == 15) ? 8'hff : (i == 0) ? 8'h00 : 8'($urandom);
         wr(`CCDC_OFS_GAIN_TRIM, g);
         wr(`CCDC_OFS_PHASE_TRIM, p);
         rd(`CCDC_OFS_GAIN_TRIM, {g[7:4], 4'h0});
         rd(`CCDC_OFS_PHASE_TRIM, p);
         settle();
         `CHK("gain_code_o", g[7:4], gain_code_o)
         `CHK("delay_cycles_o", p, delay_cycles_o)
         smp_on = 1'b1;
         repeat (40) @(posedge ref_clk_i);
         #1 smp_on = 1'b0;
      end
      $display("test trims done");
      for (int i = 0; i < 32; i++) begin
         s = $urandom;
         first_cfg_i = {1'($urandom), 1'b0, 1'($urandom)};
         second_cfg_i = {1'($urandom), 1'b0, 1'($urandom)};
         wr(`CCDC_OFS_SCAN_SEL, s);
         rd(`CCDC_OFS_SCAN_SEL, s);
         settle();
         m = {pins(s[`CCDC_BIT_CH2_SCAN], second_cfg_i, s),
              pins(s[`CCDC_BIT_CH1_SCAN], first_cfg_i, s)};
         `CHK("pin_mask_o", m, pin_mask_o)
         scan_step_i = 1'b1;
         @(posedge ref_clk_i);
         #1 scan_step_i = 1'b0;
         n = 0;
         repeat (14) begin
            @(posedge ref_clk_i);
            n += (pin_valid_o === 1'b1);
            if (pin_valid_o === 1'b1) `CHK("pin_sel_o", 1'b1, $onehot(pin_sel_o & m))
         end
         #1;
         `CHK("pin_valid_o count", $countones(m), n)
      end
      $display("test scan_select done");
      `CHK("reads outstanding", 0, exp_q.size())
      report_and_stop();
   end
endmodule : ccdc_top_test
